/* rtl/eifl_pkg.sv */
/*
 * Constants, register map and carrier types for the external interrupt
 * flag and exception entry block. Assumes a single 100 MHz clock domain.
 */
// Function
// - Let current instruction finish, 1 to 13 states.
// - Push 4, vector 2, fetch 4, internal 4.
// - Word accesses force address bit 0 low.
// - Every stack access is a word transfer.
// - Flags saved as word, restored from even byte.
// - Select 0 to 1, pin low, falling edge sets flag.
// - Select 1 to 0, pin low, rising edge sets flag.
// - Wakeup select 0 to 1, pin low sets flag.
// - Clear right after select write is ignored.
// - Wakeup flag set on falling edge, sticky.
// - Flags clear only by writing 0.
// - Each interrupt input has own edge select bit.
package eifl_pkg;
    // ************************************************************
    // Register offsets.
    // ************************************************************
    localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_WK_FLAGS = 4'h1;
    localparam logic [3:0] ADDR_EDGE_SEL = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FSEL = 4'h3;
    localparam logic [3:0] ADDR_WK_FSEL = 4'h4;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h5;
    localparam logic [3:0] ADDR_WK_EN = 4'h6;
    localparam logic [3:0] ADDR_COND_FLAGS = 4'h7;
    localparam logic [3:0] ADDR_EVT_STAT = 4'h8;
    localparam logic [3:0] ADDR_EVT_MASK = 4'h9;
    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int COND_I_BIT = 7;
    localparam logic [7:0] COND_FLAGS_RST = 8'h80;
    localparam int EVT_IRQ_BIT = 0;
    localparam int EVT_WK_BIT = 1;
    localparam int EVT_ENTRY_BIT = 2;
    // ************************************************************
    // Exception entry timing in states, vector numbers and clear guard count.
    // ************************************************************
    localparam logic [3:0] WAIT_MAX_STATES = 4'hD;
    localparam logic [3:0] PUSH_STATES = 4'h4;
    localparam logic [3:0] VECT_STATES = 4'h2;
    localparam logic [3:0] FETCH_STATES = 4'h4;
    localparam logic [3:0] INTL_STATES = 4'h4;
    localparam logic [7:0] VEC_IRQ_BASE = 8'h04;
    localparam logic [7:0] VEC_WAKEUP = 8'h09;
    localparam logic [1:0] CLR_GUARD_INIT = 2'h2;
    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [2:0] {
        EIFL_IDLE = 3'b000,
        EIFL_WAIT = 3'b001,
        EIFL_PUSH = 3'b010,
        EIFL_VECT = 3'b011,
        EIFL_FETCH = 3'b100,
        EIFL_INTL = 3'b101
    } eifl_state_t;
    // One word access towards memory; address bit 0 is always zero.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } eifl_mem_req_t;
endpackage

/* rtl/eifl_top.sv */
/*
 * External interrupt request flags, pin function switch side effects and
 * the exception entry sequence that pushes the program counter and the
 * condition flags. Assumes inputs synchronous to ref_clk_i and a CPU that
 * pulses instr_end_i at the end of each instruction.
 */
`timescale 1ns/100ps
module eifl_top #(
    parameter int IRQ_N = 5,
    parameter int WK_N = 8
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [IRQ_N-1:0] irq_pin_i,
    input wire logic [WK_N-1:0] wakeup_pin_i,
    input wire logic instr_end_i,
    input wire logic [15:0] pc_i,
    input wire logic [15:0] stack_pointer_i,
    input wire logic return_from_exception_i,
    input wire logic [15:0] stack_word_i,
    input wire logic [15:0] mem_rdata_i,
    output eifl_pkg::eifl_mem_req_t mem_req_o,
    output logic [15:0] handler_pc_o,
    output logic handler_start_o,
    output logic [7:0] condition_flags_o,
    output logic int_o
);
    // Refuse input counts that the 8-bit register lanes cannot hold.
    if (IRQ_N < 1 || IRQ_N > 8 || WK_N < 1 || WK_N > 8) begin : g_bad_count
        $error("eifl_top: input counts must lie in 1 to 8.");
    end

    // ************************************************************
    // Helper functions.
    // ************************************************************
    // Word accesses drop the low address bit so they stay aligned.
    function automatic logic [15:0] word_addr(input logic [15:0] a);
        word_addr = {a[15:1], 1'b0};
    endfunction

    // Register file, pin history and sequencer state.
    logic [IRQ_N-1:0] irq_request_flags_ff, nxt_irq_request_flags;
    logic [WK_N-1:0] wakeup_request_flags_ff, nxt_wakeup_request_flags;
    logic [IRQ_N-1:0] edge_select_reg_ff;
    logic [IRQ_N-1:0] irq_fsel_ff;
    logic [WK_N-1:0] wakeup_fsel_ff;
    logic [IRQ_N-1:0] irq_en_ff;
    logic [WK_N-1:0] wk_en_ff;
    logic [7:0] cond_flags_ff, nxt_cond_flags;
    logic [2:0] evt_stat_ff, nxt_evt_stat;
    logic [2:0] evt_mask_ff;
    logic [IRQ_N-1:0] irq_pin_ff;
    logic [WK_N-1:0] wk_pin_ff;
    logic [1:0] clr_guard_ff, nxt_clr_guard;
    logic [7:0] rdata_ff;
    eifl_pkg::eifl_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] vec_ff, nxt_vec;
    logic [15:0] handler_pc_ff, nxt_handler_pc;
    logic handler_start_ff;
    eifl_pkg::eifl_mem_req_t mem_req_ff, nxt_mem_req;

    // ************************************************************
    // Register decode.
    // ************************************************************
    wire logic wr_irqf = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_IRQ_FLAGS;
    wire logic wr_wkf = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_WK_FLAGS;
    wire logic wr_edge = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_EDGE_SEL;
    wire logic wr_ifsel = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_IRQ_FSEL;
    wire logic wr_wfsel = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_WK_FSEL;
    wire logic wr_ien = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_IRQ_EN;
    wire logic wr_wen = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_WK_EN;
    wire logic wr_cond = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_COND_FLAGS;
    wire logic wr_emask = reg_wr_i && reg_addr_i == eifl_pkg::ADDR_EVT_MASK;
    wire logic rd_estat = reg_rd_i && reg_addr_i == eifl_pkg::ADDR_EVT_STAT;
    // A clear is honoured only once an instruction lies after a select write.
    wire logic clr_ok = (clr_guard_ff == 2'h0);

    // ************************************************************
    // Flag setting conditions.
    // ************************************************************
    // New select values as written this cycle, else the held values.
    wire logic [IRQ_N-1:0] irq_fsel_new = wr_ifsel ? reg_wdata_i[IRQ_N-1:0] : irq_fsel_ff;
    wire logic [WK_N-1:0] wk_fsel_new = wr_wfsel ? reg_wdata_i[WK_N-1:0] : wakeup_fsel_ff;
    // Real edges on pins already configured for interrupt input.
    wire logic [IRQ_N-1:0] irq_fall = irq_pin_ff & ~irq_pin_i;
    wire logic [IRQ_N-1:0] irq_rise = ~irq_pin_ff & irq_pin_i;
    wire logic [IRQ_N-1:0] irq_edge = irq_fsel_ff &
        ((irq_fall & ~edge_select_reg_ff) | (irq_rise & edge_select_reg_ff));
    wire logic [WK_N-1:0] wk_edge = wakeup_fsel_ff & wk_pin_ff & ~wakeup_pin_i;
    // Switching the function while the pin is low looks like an edge.
    wire logic [IRQ_N-1:0] irq_sw_up = ~irq_fsel_ff & irq_fsel_new & ~irq_pin_i &
        ~edge_select_reg_ff;
    wire logic [IRQ_N-1:0] irq_sw_dn = irq_fsel_ff & ~irq_fsel_new & ~irq_pin_i &
        edge_select_reg_ff;
    wire logic [WK_N-1:0] wk_sw_up = ~wakeup_fsel_ff & wk_fsel_new & ~wakeup_pin_i;
    // Both causes feed the same flag, so the rest of the logic sees no difference.
    wire logic [IRQ_N-1:0] irq_set = irq_edge | irq_sw_up | irq_sw_dn;
    wire logic [WK_N-1:0] wk_set = wk_edge | wk_sw_up;

    // ************************************************************
    // Interrupt request towards the sequencer.
    // ************************************************************
    wire logic [IRQ_N-1:0] irq_act = irq_request_flags_ff & irq_en_ff;
    wire logic wk_act = |(wakeup_request_flags_ff & wk_en_ff);
    wire logic req_any = (|irq_act | wk_act) && !cond_flags_ff[eifl_pkg::COND_I_BIT];

    // Lowest numbered input wins; wakeup inputs share one vector.
    logic [7:0] sel_vec;
    always_comb begin
        sel_vec = eifl_pkg::VEC_WAKEUP;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (irq_act[i]) begin
                sel_vec = eifl_pkg::VEC_IRQ_BASE + 8'(i);
            end
        end
    end

    // ************************************************************
    // Flag and status next values.
    // ************************************************************
    // Set wins over a clear arriving in the same cycle; writing 1 changes nothing.
    always_comb begin
        nxt_irq_request_flags = irq_request_flags_ff;
        if (wr_irqf && clr_ok) begin
            nxt_irq_request_flags = irq_request_flags_ff & reg_wdata_i[IRQ_N-1:0];
        end
        nxt_irq_request_flags = nxt_irq_request_flags | irq_set;
        nxt_wakeup_request_flags = wakeup_request_flags_ff;
        if (wr_wkf && clr_ok) begin
            nxt_wakeup_request_flags = wakeup_request_flags_ff & reg_wdata_i[WK_N-1:0];
        end
        nxt_wakeup_request_flags = nxt_wakeup_request_flags | wk_set;
        // Event status clears on read, new events still land.
        nxt_evt_stat = rd_estat ? 3'h0 : evt_stat_ff;
        nxt_evt_stat[eifl_pkg::EVT_IRQ_BIT] = nxt_evt_stat[eifl_pkg::EVT_IRQ_BIT] | (|irq_set);
        nxt_evt_stat[eifl_pkg::EVT_WK_BIT] = nxt_evt_stat[eifl_pkg::EVT_WK_BIT] | (|wk_set);
        nxt_evt_stat[eifl_pkg::EVT_ENTRY_BIT] = nxt_evt_stat[eifl_pkg::EVT_ENTRY_BIT] |
            handler_start_ff;
    end

    // Guard counts the writing instruction's end and one more after it.
    always_comb begin
        nxt_clr_guard = clr_guard_ff;
        if (wr_ifsel || wr_wfsel) begin
            nxt_clr_guard = eifl_pkg::CLR_GUARD_INIT;
        end else if (instr_end_i && clr_guard_ff != 2'h0) begin
            nxt_clr_guard = clr_guard_ff - 2'h1;
        end
    end

    // ************************************************************
    // Exception entry sequencer.
    // ************************************************************
    // Stack addresses below the caller's pointer, both word aligned.
    wire logic [15:0] sp_pc = word_addr(stack_pointer_i - 16'h0002);
    wire logic [15:0] sp_cc = word_addr(stack_pointer_i - 16'h0004);
    wire logic [3:0] cnt_inc = cnt_ff + 4'h1;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_vec = vec_ff;
        nxt_handler_pc = handler_pc_ff;
        nxt_cond_flags = wr_cond ? reg_wdata_i : cond_flags_ff;
        nxt_mem_req = '0;
        unique case (state_ff)
            eifl_pkg::EIFL_IDLE: begin
                if (req_any) begin
                    nxt_state = eifl_pkg::EIFL_WAIT;
                    nxt_vec = sel_vec;
                    nxt_cnt = 4'h1;
                end
            end
            eifl_pkg::EIFL_WAIT: begin
                // The instruction in progress ends on its own strobe, at most 13 states.
                if (instr_end_i || cnt_ff == eifl_pkg::WAIT_MAX_STATES) begin
                    nxt_state = eifl_pkg::EIFL_PUSH;
                    nxt_cnt = 4'h0;
                end else begin
                    nxt_cnt = cnt_inc;
                end
            end
            eifl_pkg::EIFL_PUSH: begin
                // Two word writes: program counter, then flags in both bytes.
                if (cnt_ff == 4'h0) begin
                    nxt_mem_req = '{wr: 1'b1, rd: 1'b0, addr: sp_pc, wdata: pc_i};
                end else if (cnt_ff == 4'h2) begin
                    nxt_mem_req = '{wr: 1'b1, rd: 1'b0, addr: sp_cc,
                        wdata: {cond_flags_ff, cond_flags_ff}};
                end
                if (cnt_inc == eifl_pkg::PUSH_STATES) begin
                    nxt_state = eifl_pkg::EIFL_VECT;
                    nxt_cnt = 4'h0;
                    nxt_cond_flags[eifl_pkg::COND_I_BIT] = 1'b1;
                end else begin
                    nxt_cnt = cnt_inc;
                end
            end
            eifl_pkg::EIFL_VECT: begin
                nxt_mem_req = '{wr: 1'b0, rd: 1'b1,
                    addr: word_addr({7'h00, vec_ff, 1'b0}), wdata: 16'h0000};
                if (cnt_inc == eifl_pkg::VECT_STATES) begin
                    nxt_state = eifl_pkg::EIFL_FETCH;
                    nxt_cnt = 4'h0;
                    nxt_handler_pc = word_addr(mem_rdata_i);
                end else begin
                    nxt_cnt = cnt_inc;
                end
            end
            eifl_pkg::EIFL_FETCH: begin
                if (cnt_inc == eifl_pkg::FETCH_STATES) begin
                    nxt_state = eifl_pkg::EIFL_INTL;
                    nxt_cnt = 4'h0;
                end else begin
                    nxt_cnt = cnt_inc;
                end
            end
            eifl_pkg::EIFL_INTL: begin
                if (cnt_inc == eifl_pkg::INTL_STATES) begin
                    nxt_state = eifl_pkg::EIFL_IDLE;
                    nxt_cnt = 4'h0;
                end else begin
                    nxt_cnt = cnt_inc;
                end
            end
            default: begin
                nxt_state = eifl_pkg::EIFL_IDLE;
                nxt_cnt = 4'h0;
            end
        endcase
        // Returning restores flags from the even byte, the odd byte is dropped.
        if (return_from_exception_i) begin
            nxt_cond_flags = stack_word_i[15:8];
        end
    end

    wire logic entry_done = state_ff == eifl_pkg::EIFL_INTL && cnt_inc == eifl_pkg::INTL_STATES;

    // ************************************************************
    // Read data mux, answered in the following cycle.
    // ************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr_i)
            eifl_pkg::ADDR_IRQ_FLAGS: rd_mux = 8'(irq_request_flags_ff);
            eifl_pkg::ADDR_WK_FLAGS: rd_mux = 8'(wakeup_request_flags_ff);
            eifl_pkg::ADDR_EDGE_SEL: rd_mux = 8'(edge_select_reg_ff);
            eifl_pkg::ADDR_IRQ_FSEL: rd_mux = 8'(irq_fsel_ff);
            eifl_pkg::ADDR_WK_FSEL: rd_mux = 8'(wakeup_fsel_ff);
            eifl_pkg::ADDR_IRQ_EN: rd_mux = 8'(irq_en_ff);
            eifl_pkg::ADDR_WK_EN: rd_mux = 8'(wk_en_ff);
            eifl_pkg::ADDR_COND_FLAGS: rd_mux = cond_flags_ff;
            eifl_pkg::ADDR_EVT_STAT: rd_mux = {5'h00, evt_stat_ff};
            eifl_pkg::ADDR_EVT_MASK: rd_mux = {5'h00, evt_mask_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // ************************************************************
    // Registers.
    // ************************************************************
    // Pins reset to the idle high level so no edge appears after reset.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_request_flags_ff <= '0;
            wakeup_request_flags_ff <= '0;
            edge_select_reg_ff <= '0;
            irq_fsel_ff <= '0;
            wakeup_fsel_ff <= '0;
            irq_en_ff <= '0;
            wk_en_ff <= '0;
            evt_stat_ff <= 3'h0;
            evt_mask_ff <= 3'h0;
            irq_pin_ff <= '1;
            wk_pin_ff <= '1;
            clr_guard_ff <= 2'h0;
            rdata_ff <= 8'h00;
        end else begin
            irq_request_flags_ff <= nxt_irq_request_flags;
            wakeup_request_flags_ff <= nxt_wakeup_request_flags;
            edge_select_reg_ff <= wr_edge ? reg_wdata_i[IRQ_N-1:0] : edge_select_reg_ff;
            irq_fsel_ff <= irq_fsel_new;
            wakeup_fsel_ff <= wk_fsel_new;
            irq_en_ff <= wr_ien ? reg_wdata_i[IRQ_N-1:0] : irq_en_ff;
            wk_en_ff <= wr_wen ? reg_wdata_i[WK_N-1:0] : wk_en_ff;
            evt_stat_ff <= nxt_evt_stat;
            evt_mask_ff <= wr_emask ? reg_wdata_i[2:0] : evt_mask_ff;
            irq_pin_ff <= irq_pin_i;
            wk_pin_ff <= wakeup_pin_i;
            clr_guard_ff <= nxt_clr_guard;
            rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // Sequencer state and its outputs.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_ff <= eifl_pkg::EIFL_IDLE;
            cnt_ff <= 4'h0;
            vec_ff <= 8'h00;
            handler_pc_ff <= 16'h0000;
            handler_start_ff <= 1'b0;
            cond_flags_ff <= eifl_pkg::COND_FLAGS_RST;
            mem_req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            vec_ff <= nxt_vec;
            handler_pc_ff <= nxt_handler_pc;
            handler_start_ff <= entry_done;
            cond_flags_ff <= nxt_cond_flags;
            mem_req_ff <= nxt_mem_req;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign mem_req_o = mem_req_ff;
    assign handler_pc_o = handler_pc_ff;
    assign handler_start_o = handler_start_ff;
    assign condition_flags_o = cond_flags_ff;
    assign int_o = |(evt_stat_ff & evt_mask_ff);
endmodule

/* tb/eifl_asserts.sv */
/*
 * Concurrent checks on the exception entry and flag restore of eifl_top.
 * Assumes one clock domain and a stack pointer and PC held steady per entry.
 */
`timescale 1ns/100ps
module eifl_asserts (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] pc_i,
    input wire logic [15:0] stack_pointer_i,
    input wire logic return_from_exception_i,
    input wire logic [15:0] stack_word_i,
    input wire eifl_pkg::eifl_mem_req_t mem_req_o,
    input wire logic handler_start_o,
    input wire logic [7:0] condition_flags_o
);
    // ****************************************
    // Stack slot decode.
    // ****************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // The PC lands two bytes below the stack top, the flags four below.
    wire logic pc_slot = mem_req_o.wr && (mem_req_o.addr == 16'((stack_pointer_i - 16'h0002) & 16'hFFFE));
    wire logic fl_slot = mem_req_o.wr && (mem_req_o.addr == 16'((stack_pointer_i - 16'h0004) & 16'hFFFE));
    // Only the even byte of a popped word matters.
    wire logic [7:0] even_byte = stack_word_i[15:8];
    // ****************************************
    // Properties.
    // ****************************************
    a_addr_even: assert property (
        (mem_req_o.wr || mem_req_o.rd) |-> !mem_req_o.addr[0]) else $error("odd word address");
    a_pc_push: assert property (
        pc_slot |-> mem_req_o.wdata == pc_i) else $error("pushed PC wrong");
    a_push_order: assert property (
        pc_slot |-> ##2 fl_slot) else $error("flags word not pushed after PC");
    a_flags_word: assert property (
        fl_slot |-> mem_req_o.wdata[15:8] == mem_req_o.wdata[7:0]) else $error("flag bytes differ");
    a_mask_entry: assert property (
        fl_slot |=> condition_flags_o[7]) else $error("mask bit not set on entry");
    a_push_start: assert property (
        pc_slot |-> !handler_start_o [*8] ##6 handler_start_o) else $error("entry length wrong");
    a_vect_start: assert property (
        mem_req_o.rd && !$past(mem_req_o.rd) |-> ##9 handler_start_o) else $error("fetch length wrong");
    a_vect_gap: assert property (
        $rose(mem_req_o.rd) |-> $past(fl_slot, 2)) else $error("vector read out of place");
    a_rte_load: assert property (
        return_from_exception_i |=> condition_flags_o == $past(even_byte)) else $error("flags not restored");
    a_start_pulse: assert property (
        handler_start_o |=> !handler_start_o) else $error("start pulse too long");
endmodule
bind eifl_top eifl_asserts u_chk (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .pc_i(pc_i),
    .stack_pointer_i(stack_pointer_i),
    .return_from_exception_i(return_from_exception_i),
    .stack_word_i(stack_word_i),
    .mem_req_o(mem_req_o),
    .handler_start_o(handler_start_o),
    .condition_flags_o(condition_flags_o)
);

/* tb/eifl_pin_model.sv */
/*
 * Board-side driver of the interrupt and wakeup pins.
 * Assumes the bench asks for pin levels; pins follow one edge later.
 */
`timescale 1ns/100ps
module eifl_pin_model #(
    parameter int IRQ_N = 5,
    parameter int WK_N = 8
) (
    input wire logic ref_clk_i,
    input wire logic [IRQ_N-1:0] irq_lvl_i,
    input wire logic [WK_N-1:0] wk_lvl_i,
    output logic [IRQ_N-1:0] irq_pin_o,
    output logic [WK_N-1:0] wakeup_pin_o
);
    // Pins are always driven; holding them high while functions switch
    // keeps false flags away, which is how most scenarios start.
    always_ff @(posedge ref_clk_i) begin
        irq_pin_o <= irq_lvl_i;
        wakeup_pin_o <= wk_lvl_i;
    end
endmodule

/* tb/eifl_tb_top.sv */
/*
 * Self-checking bench for eifl_top: register tasks, pin switching cases,
 * and two exception entries. Assumes the pin model and the bound checker.
 */
`timescale 1ns/100ps
module eifl_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ie = 1'b0;
    logic ret_exc = 1'b0;
    // Program counter, stack pointer and vector word driven by the bench.
    logic [15:0] pc = 16'h3456;
    logic [15:0] stk_ptr = 16'h0F00;
    logic [15:0] vec_word = 16'h0246;
    logic [15:0] sw = 16'h0000;
    logic [4:0] irq_lvl = 5'h1F;
    logic [7:0] wk_lvl = 8'hFF;
    logic [4:0] irq_pin;
    logic [7:0] wk_pin;
    logic [7:0] rdata;
    logic [7:0] cf;
    logic [15:0] hpc;
    logic [15:0] vaddr = 16'h0000;
    logic hs;
    logic intr;
    eifl_pkg::eifl_mem_req_t mreq;
    int num_errors = 0;
    int tests_run = 0;
    int n;
    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk = ~clk;
    end
    eifl_pin_model #(.IRQ_N(5), .WK_N(8)) pins (.ref_clk_i(clk), .irq_lvl_i(irq_lvl),
        .wk_lvl_i(wk_lvl), .irq_pin_o(irq_pin), .wakeup_pin_o(wk_pin));
    // PC, stack pointer and vector word are fixed so pushes are predictable.
    eifl_top #(.IRQ_N(5), .WK_N(8)) dut (.ref_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .irq_pin_i(irq_pin), .wakeup_pin_i(wk_pin), .instr_end_i(ie), .pc_i(pc),
        .stack_pointer_i(stk_ptr), .return_from_exception_i(ret_exc), .stack_word_i(sw),
        .mem_rdata_i(vec_word), .mem_req_o(mreq), .handler_pc_o(hpc),
        .handler_start_o(hs), .condition_flags_o(cf), .int_o(intr));
    // Compare and count.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic chk_int(input logic e);
        @(posedge clk);
        #1;
        check({15'h0000, intr}, {15'h0000, e});
    endtask
    // Two instruction ends let the clear guard expire before clearing.
    task automatic clear_flags();
        repeat (2) begin
            @(posedge clk);
            ie <= 1'b1;
            @(posedge clk);
            ie <= 1'b0;
        end
        wr_reg(eifl_pkg::ADDR_IRQ_FLAGS, 8'h00);
        wr_reg(eifl_pkg::ADDR_WK_FLAGS, 8'h00);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(4'hF, 8'h00);
        check({8'h00, cf}, {8'h00, eifl_pkg::COND_FLAGS_RST});
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h1F);
        wr_reg(eifl_pkg::ADDR_WK_FSEL, 8'hFF);
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h00);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd_chk(eifl_pkg::ADDR_WK_FLAGS, 8'h00);
        $display("pins high switch done");
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h1F);
        wr_reg(eifl_pkg::ADDR_EDGE_SEL, 8'h05);
        irq_lvl <= 5'h00;
        wk_lvl <= 8'h00;
        repeat (3) @(posedge clk);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h1A);
        rd_chk(eifl_pkg::ADDR_WK_FLAGS, 8'hFF);
        irq_lvl <= 5'h1F;
        repeat (3) @(posedge clk);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h1F);
        clear_flags();
        wr_reg(eifl_pkg::ADDR_IRQ_FLAGS, 8'h1F);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd_chk(eifl_pkg::ADDR_WK_FLAGS, 8'h00);
        $display("real edges done");
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h00);
        irq_lvl <= 5'h00;
        wr_reg(eifl_pkg::ADDR_EDGE_SEL, 8'h00);
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h1F);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h1F);
        wr_reg(eifl_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h1F);
        clear_flags();
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h00);
        wr_reg(eifl_pkg::ADDR_EDGE_SEL, 8'h1F);
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h00);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h1F);
        wr_reg(eifl_pkg::ADDR_WK_FSEL, 8'h00);
        clear_flags();
        rd_chk(eifl_pkg::ADDR_WK_FLAGS, 8'h00);
        wr_reg(eifl_pkg::ADDR_WK_FSEL, 8'hFF);
        rd_chk(eifl_pkg::ADDR_WK_FLAGS, 8'hFF);
        clear_flags();
        $display("function switch done");
        rd_chk(eifl_pkg::ADDR_EVT_STAT, 8'h03);
        wr_reg(eifl_pkg::ADDR_IRQ_EN, 8'h01);
        wr_reg(eifl_pkg::ADDR_EVT_MASK, 8'h07);
        wr_reg(eifl_pkg::ADDR_EDGE_SEL, 8'h00);
        wr_reg(eifl_pkg::ADDR_COND_FLAGS, 8'h00);
        chk_int(1'b0);
        wr_reg(eifl_pkg::ADDR_IRQ_FSEL, 8'h01);
        n = 0;
        // With no instruction end the wait is cut at 13 states.
        while (hs !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
            if (mreq.rd === 1'b1) vaddr = mreq.addr;
        end
        // Thirteen wait states, then 4, 2, 4 and 4 entry states, then the start pulse.
        check(16'(n), 16'h001C);
        check(vaddr, 16'h0008);
        check(hpc, 16'h0246);
        check({8'h00, cf}, 16'h0080);
        chk_int(1'b1);
        wr_reg(eifl_pkg::ADDR_EVT_MASK, 8'h00);
        chk_int(1'b0);
        wr_reg(eifl_pkg::ADDR_EVT_MASK, 8'h07);
        chk_int(1'b1);
        rd_chk(eifl_pkg::ADDR_EVT_STAT, 8'h05);
        chk_int(1'b0);
        rd_chk(eifl_pkg::ADDR_IRQ_FLAGS, 8'h01);
        @(posedge clk);
        sw <= 16'hC53A;
        ret_exc <= 1'b1;
        @(posedge clk);
        ret_exc <= 1'b0;
        #1;
        check({8'h00, cf}, 16'h00C5);
        $display("entry and return done");
        // Unmasking with the flag still pending starts a second entry; an
        // instruction end in the first wait state cuts the wait to one state.
        wr_reg(eifl_pkg::ADDR_COND_FLAGS, 8'h00);
        @(posedge clk);
        ie <= 1'b1;
        @(posedge clk);
        ie <= 1'b0;
        n = 2;
        while (hs !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n), 16'h0010);
        check({8'h00, cf}, 16'h0080);
        $display("short wait entry done");
        finish_test();
    end
endmodule
